// ---- dv/tpcg_clock_gen_tb.sv ----
`timescale 1ns/10ps

module tpcg_clock_gen_tb;
    import tpcg_pkg::*;

    typedef struct {
        logic       idle;
        logic       pd;
        logic       wake;
        tpcg_mode_e mode;
        logic       osc;
        int         cpu_n;
        int         per_n;
    } tpcg_row_s;

    logic       sys_clk = 1'h0;
    logic       reset   = 1'h1;
    logic       crystal, osc_en, idle_req, pd_req, wake_irq, mon_on;
    logic       ph1, ph2, cpu1, cpu2, per1, per2, sci, sco, r1, r2, last_one;
    logic       p_ph1, p_ph2, p_sci, p_cpu, p_per;
    tpcg_mode_e mode;
    int         num_errors, total_checks, cycles, cpu_cnt, per_cnt, c0, p0;
    tpcg_row_s  rows [8];

    always #5 sys_clk = ~sys_clk;

    tpcg_xtal_model u_xtal (.osc_enable(osc_en), .crystal(crystal));

    tpcg_clock_gen u_dut (
        .SYS_CLK(sys_clk), .RESET(reset), .CRYSTAL_INPUT(crystal), .OSC_ENABLE(osc_en),
        .IDLE_REQ(idle_req), .POWERDOWN_REQ(pd_req), .WAKE_IRQ(wake_irq),
        .PHASE_ONE(ph1), .PHASE_TWO(ph2), .CPU_PHASE_ONE(cpu1), .CPU_PHASE_TWO(cpu2),
        .PERIPH_PHASE_ONE(per1), .PERIPH_PHASE_TWO(per2),
        .STATE_CLOCK_INTERNAL(sci), .STATE_CLOCK_OUTPUT(sco), .MODE(mode)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // cycle monitor, sampled where outputs have settled
    // ---------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (reset) begin
            last_one = 1'h1;
        end else if (mon_on) begin
            r1 = ph1 & ~p_ph1;
            r2 = ph2 & ~p_ph2;
            check("phase overlap", ph1 & ph2, 32'h0);
            check("phase alternation", (r1 & last_one) | (r2 & ~last_one), 32'h0);
            if (r1) last_one = 1'h1;
            if (r2) last_one = 1'h0;
            check("pin copy", sco, p_sci);
            check("state clock", sci, (mode === TPCG_PDOWN) ? 1'h0 : r1 ? 1'h1 : r2 ? 1'h0 : p_sci);
            check("cpu gating", (cpu1 & ~ph1) | (cpu2 & ~ph2), 32'h0);
            check("periph gating", (per1 & ~ph1) | (per2 & ~ph2), 32'h0);
            if (mode === TPCG_PDOWN)
                check("pdown clocks", {ph1, ph2, cpu1, cpu2, per1, per2, sci, osc_en}, 32'h0);
            if (cpu1 & ~p_cpu) cpu_cnt++;
            if (per1 & ~p_per) per_cnt++;
        end
        p_ph1 = ph1;
        p_ph2 = ph2;
        p_sci = sci;
        p_cpu = cpu1;
        p_per = per1;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            give_verdict();
        end
    end

    // request window, settle, then a 64-cycle count of cpu and peripheral phase_one rises
    task automatic run_row(input tpcg_row_s r);
        @(negedge sys_clk);
        idle_req = r.idle;
        pd_req   = r.pd;
        wake_irq = r.wake;
        repeat (20) @(negedge sys_clk);
        idle_req = 1'h0;
        pd_req   = 1'h0;
        wake_irq = 1'h0;
        repeat (40) @(negedge sys_clk);
        c0 = cpu_cnt;
        p0 = per_cnt;
        repeat (64) @(negedge sys_clk);
        check("mode", mode, r.mode);
        check("osc enable", osc_en, r.osc);
        check("cpu rises", cpu_cnt - c0, r.cpu_n);
        check("periph rises", per_cnt - p0, r.per_n);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {idle_req, pd_req, wake_irq, mon_on} = 4'h0;
        {num_errors, total_checks, cycles, cpu_cnt, per_cnt} = '0;
        rows[0] = '{1'h0, 1'h0, 1'h0, TPCG_RUN,   1'h1, 4, 4};
        rows[1] = '{1'h1, 1'h0, 1'h0, TPCG_IDLE,  1'h1, 0, 4};
        rows[2] = '{1'h0, 1'h0, 1'h1, TPCG_RUN,   1'h1, 4, 4};
        rows[3] = '{1'h0, 1'h1, 1'h0, TPCG_PDOWN, 1'h0, 0, 0};
        rows[4] = '{1'h1, 1'h0, 1'h0, TPCG_PDOWN, 1'h0, 0, 0};
        rows[5] = '{1'h0, 1'h0, 1'h1, TPCG_RUN,   1'h1, 4, 4};
        rows[6] = '{1'h1, 1'h1, 1'h0, TPCG_PDOWN, 1'h0, 0, 0};
        rows[7] = '{1'h0, 1'h0, 1'h1, TPCG_RUN,   1'h1, 4, 4};
        repeat (10) @(negedge sys_clk);
        check("reset clocks", {ph1, ph2, cpu1, cpu2, per1, per2, sci}, 32'h0);
        check("reset osc", osc_en, 1'h1);
        check("reset mode", mode, TPCG_RUN);
        reset  = 1'h0;
        mon_on = 1'h1;
        foreach (rows[i]) run_row(rows[i]);
        // one-cycle idle pulse is held pending, then reset ends idle
        @(negedge sys_clk);
        idle_req = 1'h1;
        @(negedge sys_clk);
        idle_req = 1'h0;
        repeat (30) @(negedge sys_clk);
        check("pulse idle", mode, TPCG_IDLE);
        reset = 1'h1;
        repeat (3) @(negedge sys_clk);
        check("reset exits idle", mode, TPCG_RUN);
        reset = 1'h0;
        run_row(rows[0]);
        give_verdict();
    end

endmodule

// ---- dv/tpcg_xtal_model.sv ----
`timescale 1ns/10ps

// ---------------------------------------------------------------
// crystal oscillator model
// ---------------------------------------------------------------
module tpcg_xtal_model #(
    parameter int HALF_NS = 40
) (
    // oscillator control
    input  wire logic osc_enable,
    // crystal pin
    output logic      crystal
);

    // off-grid start keeps crystal edges away from the system clock edges
    initial begin
        crystal = 1'h0;
        #3;
        forever begin
            #(HALF_NS);
            // stopped oscillator rests low
            if (osc_enable) begin
                crystal = ~crystal;
            end else begin
                crystal = 1'h0;
            end
        end
    end

endmodule

// ---- rtl/tpcg_clock_gen.sv ----
`timescale 1ns/10ps

// Summary of operation
// - crystal input frequency is halved before the phase generators.
// - two phase clocks, active high, never high together.
// - state clock rises on phase_one rise, falls on phase_two rise.
// - cpu and peripheral clock branches are gated independently.
// - state clock pin is a delayed copy of the internal state clock.
// - one state time is phase_one plus phase_two, two input periods.
// - idle stops the cpu branch, peripheral branch keeps running.
// - reset or an enabled interrupt ends idle, restarting the cpu branch.
// - powerdown holds all clocks low, the state clock pin one cycle late, and disables the oscillator.
// - powerdown freezes the divider state but clears pending idle and powerdown requests.
module tpcg_clock_gen (
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RESET,
    // crystal side
    input  wire logic CRYSTAL_INPUT,
    output logic      OSC_ENABLE,
    // power management requests
    input  wire logic IDLE_REQ,
    input  wire logic POWERDOWN_REQ,
    input  wire logic WAKE_IRQ,
    // phase clocks
    output logic      PHASE_ONE,
    output logic      PHASE_TWO,
    output logic      CPU_PHASE_ONE,
    output logic      CPU_PHASE_TWO,
    output logic      PERIPH_PHASE_ONE,
    output logic      PERIPH_PHASE_TWO,
    // state clock
    output logic      STATE_CLOCK_INTERNAL,
    output logic      STATE_CLOCK_OUTPUT,
    output tpcg_pkg::tpcg_mode_e MODE
);
    import tpcg_pkg::*;

    // ---------------------------------------------------------------
    // crystal synchroniser
    // ---------------------------------------------------------------
    logic xtal_s2;
    logic xtal_s3;
    logic xtal_rise;

    tpcg_sync3 u_xtal_sync (
        .sys_clk     (SYS_CLK),
        .reset       (RESET),
        .pin_in      (CRYSTAL_INPUT),
        .stage_two   (xtal_s2),
        .stage_three (xtal_s3)
    );

    assign xtal_rise = xtal_s2 & ~xtal_s3;

    // ---------------------------------------------------------------
    // mode control
    // ---------------------------------------------------------------
    tpcg_mode_e mode_q;
    tpcg_mode_e mode_d;
    logic       idle_pend_q;
    logic       idle_pend_d;
    logic       pdown_pend_q;
    logic       pdown_pend_d;
    logic       cpu_en_q;
    logic       cpu_en_d;
    logic       per_en_q;
    logic       per_en_d;
    logic       osc_q;
    logic       osc_d;
    logic       resume_q;
    logic       resume_d;

    always_comb begin
        mode_d       = mode_q;
        idle_pend_d  = idle_pend_q | IDLE_REQ;
        pdown_pend_d = pdown_pend_q | POWERDOWN_REQ;
        case (mode_q)
            TPCG_RUN: begin
                if (xtal_rise && pdown_pend_d) begin
                    mode_d       = TPCG_PDOWN;
                    pdown_pend_d = 1'h0;
                    idle_pend_d  = 1'h0;
                end else if (xtal_rise && idle_pend_d) begin
                    mode_d      = TPCG_IDLE;
                    idle_pend_d = 1'h0;
                end
            end
            TPCG_IDLE: begin
                if (xtal_rise && WAKE_IRQ) begin
                    mode_d = TPCG_RUN;
                end else if (xtal_rise && pdown_pend_d) begin
                    mode_d       = TPCG_PDOWN;
                    pdown_pend_d = 1'h0;
                end
                idle_pend_d = 1'h0;
            end
            TPCG_PDOWN: begin
                // phases already low, leave at once
                if (WAKE_IRQ) begin
                    mode_d = TPCG_RUN;
                end
                idle_pend_d  = 1'h0;
                pdown_pend_d = 1'h0;
            end
            default: begin
                mode_d = TPCG_RUN;
            end
        endcase
        // idle gates only the cpu branch
        cpu_en_d = (mode_d == TPCG_RUN);
        per_en_d = (mode_d != TPCG_PDOWN);
        osc_d    = (mode_d != TPCG_PDOWN);
        // after powerdown, phases wait for a crystal rise
        resume_d = (mode_q == TPCG_PDOWN) || (resume_q && !xtal_rise);
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            mode_q       <= TPCG_RUN;
            idle_pend_q  <= 1'h0;
            pdown_pend_q <= 1'h0;
            cpu_en_q     <= TPCG_ENABLE_RESET;
            per_en_q     <= TPCG_ENABLE_RESET;
            osc_q        <= TPCG_OSC_RESET;
            resume_q     <= 1'h0;
        end else begin
            mode_q       <= mode_d;
            idle_pend_q  <= idle_pend_d;
            pdown_pend_q <= pdown_pend_d;
            cpu_en_q     <= cpu_en_d;
            per_en_q     <= per_en_d;
            osc_q        <= osc_d;
            resume_q     <= resume_d;
        end
    end

    // ---------------------------------------------------------------
    // divider and phase generator
    // ---------------------------------------------------------------
    logic half_q;
    logic half_d;
    logic ph1_q;
    logic ph1_d;
    logic ph2_q;
    logic ph2_d;
    logic cph1_q;
    logic cph1_d;
    logic cph2_q;
    logic cph2_d;
    logic pph1_q;
    logic pph1_d;
    logic pph2_q;
    logic pph2_d;
    logic sclk_q;
    logic sclk_d;
    logic spin_q;
    logic spin_d;
    logic frozen;

    assign frozen = (mode_d == TPCG_PDOWN);

    always_comb begin
        half_d = (xtal_rise && !frozen) ? ~half_q : half_q;
        // one gap cycle after each input rising edge
        if (frozen || xtal_rise || resume_d) begin
            ph1_d = 1'h0;
            ph2_d = 1'h0;
        end else begin
            ph1_d = half_q;
            ph2_d = ~half_q;
        end
        cph1_d = ph1_d & cpu_en_d;
        cph2_d = ph2_d & cpu_en_d;
        pph1_d = ph1_d & per_en_d;
        pph2_d = ph2_d & per_en_d;
        if (frozen) begin
            sclk_d = 1'h0;
        end else if (ph1_d && !ph1_q) begin
            sclk_d = 1'h1;
        end else if (ph2_d && !ph2_q) begin
            sclk_d = 1'h0;
        end else begin
            sclk_d = sclk_q;
        end
        // pin copy lags the internal clock
        spin_d = sclk_q;
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            half_q <= TPCG_HALF_RESET;
            ph1_q  <= TPCG_PHASE_RESET;
            ph2_q  <= TPCG_PHASE_RESET;
            cph1_q <= TPCG_PHASE_RESET;
            cph2_q <= TPCG_PHASE_RESET;
            pph1_q <= TPCG_PHASE_RESET;
            pph2_q <= TPCG_PHASE_RESET;
            sclk_q <= TPCG_PHASE_RESET;
            spin_q <= TPCG_PHASE_RESET;
        end else begin
            half_q <= half_d;
            ph1_q  <= ph1_d;
            ph2_q  <= ph2_d;
            cph1_q <= cph1_d;
            cph2_q <= cph2_d;
            pph1_q <= pph1_d;
            pph2_q <= pph2_d;
            sclk_q <= sclk_d;
            spin_q <= spin_d;
        end
    end

    assign PHASE_ONE            = ph1_q;
    assign PHASE_TWO            = ph2_q;
    assign CPU_PHASE_ONE        = cph1_q;
    assign CPU_PHASE_TWO        = cph2_q;
    assign PERIPH_PHASE_ONE     = pph1_q;
    assign PERIPH_PHASE_TWO     = pph2_q;
    assign STATE_CLOCK_INTERNAL = sclk_q;
    assign STATE_CLOCK_OUTPUT   = spin_q;
    assign OSC_ENABLE           = osc_q;
    assign MODE                 = mode_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    phase_overlap_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET) !(ph1_q && ph2_q))
        else $error("phases overlap");

    divider_toggle_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (xtal_rise && mode_d != TPCG_PDOWN) |=> (half_q != $past(half_q)))
        else $error("divider missed an input edge");

    state_period_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (xtal_rise && mode_q == TPCG_RUN && mode_d == TPCG_RUN)
        |=> !ph1_q && !ph2_q ##1 (ph1_q != ph2_q))
        else $error("phase not produced after input edge");

    sclk_rise_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        $rose(ph1_q) |-> sclk_q)
        else $error("state clock did not rise with phase one");

    pin_delay_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        spin_q == $past(sclk_q))
        else $error("state clock pin not a delayed copy");

    idle_gate_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (mode_q == TPCG_IDLE && xtal_rise && !WAKE_IRQ && !pdown_pend_d)
        |=> ##1 (!cph1_q && !cph2_q && (pph1_q || pph2_q)))
        else $error("idle branch gating wrong");

    idle_wake_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (mode_q == TPCG_IDLE && xtal_rise && WAKE_IRQ) |=> mode_q == TPCG_RUN)
        else $error("interrupt did not end idle");

    pdown_low_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        mode_q == TPCG_PDOWN |-> !ph1_q && !ph2_q && !pph1_q && !cph1_q
                                  && !pph2_q && !cph2_q && !sclk_q && !osc_q)
        else $error("clock running in powerdown");

    pdown_hold_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (mode_q == TPCG_PDOWN && $past(mode_q) == TPCG_PDOWN) |-> $stable(half_q))
        else $error("divider state disturbed in powerdown");

    gate_switch_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        ($changed(cpu_en_q) || $changed(per_en_q)) |-> (!ph1_q && !ph2_q))
        else $error("branch gate changed during a phase");

    branch_split_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (cpu_en_q |-> (cph1_q == ph1_q && pph1_q == ph1_q)))
        else $error("branch does not follow phase");

endmodule

// ---- rtl/tpcg_pkg.sv ----
package tpcg_pkg;

    // ---------------------------------------------------------------
    // divider and reset values
    // ---------------------------------------------------------------
    localparam int   TPCG_DIVIDE_RATIO    = 2;
    localparam int   TPCG_SYNC_STAGES     = 3;
    localparam logic TPCG_HALF_RESET      = 1'h0;
    localparam logic TPCG_PHASE_RESET     = 1'h0;
    localparam logic TPCG_ENABLE_RESET    = 1'h1;
    localparam logic TPCG_OSC_RESET       = 1'h1;
    localparam logic TPCG_SYNC_RESET      = 1'h0;

    // ---------------------------------------------------------------
    // operating modes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        TPCG_RUN,
        TPCG_IDLE,
        TPCG_PDOWN
    } tpcg_mode_e;

endpackage

// ---- rtl/tpcg_sync3.sv ----
`timescale 1ns/10ps

module tpcg_sync3 (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // pin in, synchronised taps out
    input  wire logic pin_in,
    output logic      stage_two,
    output logic      stage_three
);
    import tpcg_pkg::*;

    logic stage_one_q;
    logic stage_two_q;
    logic stage_three_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stage_one_q   <= TPCG_SYNC_RESET;
            stage_two_q   <= TPCG_SYNC_RESET;
            stage_three_q <= TPCG_SYNC_RESET;
        end else begin
            stage_one_q   <= pin_in;
            stage_two_q   <= stage_one_q;
            stage_three_q <= stage_two_q;
        end
    end

    assign stage_two   = stage_two_q;
    assign stage_three = stage_three_q;

endmodule
